// ---- rtl/sgcf_global_config.sv ----
// global configuration word with diagnostic output routing
// assumes a serial interface on clk hands one access per reg_req pulse;
// step, direction, enable and mode-select come from pins
`timescale 1ns/10ps
`include "sgcf_cfg.svh"

// How it works
// (R01) recalibrate zero crossing while driver disabled
// (R02) standstill after 2^18 or 2^20 idle clocks
// (R03) bit 2 enables voltage pwm chopper mode
// (R04) bit 3 filters step input, resets to one
// (R05) bit 4 inverts motor direction
// (R06) first output flags driver faults in mode one
// (R07) first output low throughout reset
// (R08) first output flags temperature prewarning in mode one
// (R09) first output flags stall in mode one
// (R10) mode zero: interrupt or toggling step output
// (R11) second output flags stall in mode one
// (R12) mode zero: position compare or direction output
// (R13) second output flags table index zero
// (R14) second output flags chopper on-state
// (R15) second output toggles on skipped steps
// (R16) write address is register plus 0x80
// (R17) configuration resets to documented defaults
// (R18) output mode select sampled after reset
module sgcf_global_config import sgcf_pkg::*; #(
	parameter int MSLUT_W = 10,
	parameter logic [20:0] IDLE_SHORT_CLK = `SGCF_IDLE_SHORT_CLK,
	parameter logic [20:0] IDLE_LONG_CLK = `SGCF_IDLE_LONG_CLK
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_req,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic driver_enable_n,
	input wire logic step_pin,
	input wire logic dir_pin,
	input wire logic external_step_output_select,
	input wire logic [3:0] chopper_off_time,
	input wire logic [MSLUT_W-1:0] mslut_position,
	input wire sgcf_event_type event_in,
	output logic step_executed,
	output logic motor_direction,
	output logic standstill,
	output logic recalibrate_active,
	output logic voltage_pwm_enable,
	output logic step_filter_enable,
	output logic first_diagnostic_output_n,
	output logic second_diagnostic_output_n
);
	sgcf_state_type st_ff;
	sgcf_state_type nxt_st;
	logic wr_hit;
	logic rd_hit;
	logic step_raw;
	logic step_evt;
	logic fault;

	// ------------------------------------------------------------------------
	// register access
	// ------------------------------------------------------------------------
	function automatic logic cbit(input logic [`SGCF_CFG_W-1:0] c, input int b);
		cbit = c[b];
	endfunction

	assign wr_hit = reg_req && reg_addr == (`SGCF_ADDR_GLOBAL_CONFIG | `SGCF_WRITE_FLAG); // [R16]
	assign rd_hit = reg_req && reg_addr == `SGCF_ADDR_GLOBAL_CONFIG; // [R16]

	// ------------------------------------------------------------------------
	// step detection
	// ------------------------------------------------------------------------
	assign step_raw = st_ff.step_q && !st_ff.step_q2;
	// filtered: edge must hold a second sample
	assign step_evt = cbit(st_ff.cfg, `SGCF_B_STEP_FILTER) ?
		(step_raw && st_ff.step_s[1]) : step_raw; // [R04]
	assign fault = event_in.over_temp || event_in.short_gnd || event_in.pump_undervoltage;

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.en_s = {st_ff.en_s[0], driver_enable_n};
		nxt_st.step_s = {st_ff.step_s[0], step_pin};
		nxt_st.dir_s = {st_ff.dir_s[0], dir_pin};
		nxt_st.sel_s = {st_ff.sel_s[0], external_step_output_select};
		nxt_st.step_q = st_ff.step_s[1];
		nxt_st.step_q2 = st_ff.step_q;
		nxt_st.rvalid = 1'b0;
		if (st_ff.init_cnt != 2'h3) begin
			nxt_st.init_cnt = st_ff.init_cnt + 2'h1;
		end
		if (st_ff.init_cnt == `SGCF_SEL_SAMPLE) begin
			nxt_st.sel = st_ff.sel_s[1]; // [R18]
		end
		if (wr_hit) begin
			nxt_st.cfg = reg_wdata[`SGCF_CFG_W-1:0]; // [R16]
		end
		if (rd_hit) begin
			nxt_st.rdata = {{(32-`SGCF_CFG_W){1'b0}}, st_ff.cfg};
			nxt_st.rvalid = 1'b1;
		end
		nxt_st.motor_dir = st_ff.dir_s[1] ^ cbit(st_ff.cfg, `SGCF_B_INVERT_DIR); // [R05]
		nxt_st.recal = cbit(st_ff.cfg, `SGCF_B_RECALIBRATE) &&
			(st_ff.en_s[1] || chopper_off_time == 4'h0); // [R01]
		if (step_evt) begin
			nxt_st.step_tgl = !st_ff.step_tgl; // [R10]
		end
		if (event_in.skipped_inc) begin
			nxt_st.skip_tgl = !st_ff.skip_tgl; // [R15]
		end
		if (st_ff.sel) begin
			nxt_st.act0 = (cbit(st_ff.cfg, `SGCF_B_FIRST_FAULT) && fault) || // [R06]
				(cbit(st_ff.cfg, `SGCF_B_FIRST_PREWARN) && event_in.prewarning) || // [R08]
				(cbit(st_ff.cfg, `SGCF_B_FIRST_STALL) && event_in.stall); // [R09]
			nxt_st.act1 = (cbit(st_ff.cfg, `SGCF_B_SECOND_STALL) && event_in.stall) || // [R11]
				(cbit(st_ff.cfg, `SGCF_B_SECOND_INDEX) && mslut_position == '0) || // [R13]
				(cbit(st_ff.cfg, `SGCF_B_SECOND_CHOP_ON) && event_in.chopper_on) || // [R14]
				(cbit(st_ff.cfg, `SGCF_B_SECOND_SKIP) && st_ff.skip_tgl); // [R15]
		end else begin
			nxt_st.act0 = cbit(st_ff.cfg, `SGCF_B_FIRST_STALL) ?
				nxt_st.step_tgl : event_in.interrupt_req; // [R10]
			nxt_st.act1 = cbit(st_ff.cfg, `SGCF_B_SECOND_STALL) ?
				st_ff.motor_dir : event_in.position_compare; // [R12]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.cfg <= `SGCF_CFG_RESET; // [R17] [R04]
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------------------
	// idle timer
	// ------------------------------------------------------------------------
	sgcf_idle_timer #(
		.SHORT_CLK(IDLE_SHORT_CLK),
		.LONG_CLK(IDLE_LONG_CLK)
	) u_idle (
		.clk(clk),
		.sys_rst(sys_rst),
		.step_evt(step_evt),
		.quick(cbit(st_ff.cfg, `SGCF_B_QUICK_IDLE)), // [R02]
		.standstill(standstill)
	);

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	assign reg_rdata = st_ff.rdata;
	assign reg_rvalid = st_ff.rvalid;
	assign step_executed = step_evt;
	assign motor_direction = st_ff.motor_dir;
	assign recalibrate_active = st_ff.recal;
	assign voltage_pwm_enable = cbit(st_ff.cfg, `SGCF_B_VOLTAGE_PWM); // [R03]
	assign step_filter_enable = cbit(st_ff.cfg, `SGCF_B_STEP_FILTER);
	assign first_diagnostic_output_n = !sys_rst && !st_ff.act0; // [R07]
	assign second_diagnostic_output_n = !st_ff.act1;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_write_stores: assert property (wr_hit |=> st_ff.cfg == $past(reg_wdata[17:0])) // [R16]
		else $error("write lost");
	a_read_answers: assert property (rd_hit |=> reg_rvalid && // [R16]
		reg_rdata[17:0] == $past(st_ff.cfg)) else $error("read wrong");
	a_reset_value: assert property ($past(sys_rst) |-> st_ff.cfg == `SGCF_CFG_RESET) // [R17]
		else $error("bad reset value");
	a_first_reset: assert property (@(posedge clk) disable iff (1'b0) // [R07]
		sys_rst |-> !first_diagnostic_output_n) else $error("first output high in reset");
	a_dir_invert: assert property (1'b1 |=> motor_direction == // [R05]
		($past(st_ff.dir_s[1]) ^ $past(st_ff.cfg[4]))) else $error("direction wrong");
	a_recal_path: assert property (st_ff.cfg[0] && st_ff.en_s[1] |=> recalibrate_active) // [R01]
		else $error("no recalibration");
	a_fault_route: assert property (st_ff.sel && st_ff.cfg[5] && fault // [R06]
		|=> !first_diagnostic_output_n) else $error("fault not shown");
	a_prewarn_route: assert property (st_ff.sel && st_ff.cfg[6] && event_in.prewarning // [R08]
		|=> !first_diagnostic_output_n) else $error("prewarning not shown");
	a_stall_first: assert property (st_ff.sel && st_ff.cfg[7] && event_in.stall // [R09]
		|=> !first_diagnostic_output_n) else $error("stall not on first");
	a_int_route: assert property (!st_ff.sel && !st_ff.cfg[7] && event_in.interrupt_req // [R10]
		|=> !first_diagnostic_output_n) else $error("interrupt not shown");
	a_step_toggle: assert property (!st_ff.sel && st_ff.cfg[7] && !wr_hit && step_evt // [R10]
		|=> first_diagnostic_output_n != $past(first_diagnostic_output_n))
		else $error("step output idle");
	a_stall_second: assert property (st_ff.sel && st_ff.cfg[8] && event_in.stall // [R11]
		|=> !second_diagnostic_output_n) else $error("stall not on second");
	a_dir_output: assert property (!st_ff.sel && st_ff.cfg[8] // [R12]
		|=> second_diagnostic_output_n == !$past(motor_direction)) else $error("dir out wrong");
	a_compare_route: assert property (!st_ff.sel && !st_ff.cfg[8] // [R12]
		&& event_in.position_compare |=> !second_diagnostic_output_n)
		else $error("compare not shown");
	a_index_route: assert property (st_ff.sel && st_ff.cfg[9] && mslut_position == '0 // [R13]
		|=> !second_diagnostic_output_n) else $error("index not shown");
	a_chop_route: assert property (st_ff.sel && st_ff.cfg[10] && event_in.chopper_on // [R14]
		|=> !second_diagnostic_output_n) else $error("on-state not shown");
	a_skip_toggle: assert property (st_ff.sel && st_ff.cfg[11:8] == 4'h8 && !wr_hit // [R15]
		&& event_in.skipped_inc
		|=> ##1 second_diagnostic_output_n != $past(second_diagnostic_output_n))
		else $error("skip toggle missing");
	a_pwm_enable: assert property (wr_hit && reg_wdata[2] |=> voltage_pwm_enable) // [R03]
		else $error("pwm not enabled");
	a_pwm_disable: assert property (wr_hit && !reg_wdata[2] |=> !voltage_pwm_enable) // [R03]
		else $error("pwm not disabled");
	a_filter_flag: assert property (wr_hit |=> step_filter_enable == $past(reg_wdata[3])) // [R04]
		else $error("filter flag wrong");
	a_sel_hold: assert property (st_ff.init_cnt == 2'h3 |=> $stable(st_ff.sel)) // [R18]
		else $error("mode select moved");

	c_cfg_write: cover property (wr_hit ##1 rd_hit);
	c_step_mode: cover property (!st_ff.sel && st_ff.cfg[7] && step_evt);
	c_fault_mode: cover property (st_ff.sel && st_ff.cfg[5] && fault);
	c_skip_mode: cover property (st_ff.sel && st_ff.cfg[11] && event_in.skipped_inc);
endmodule

// ---- rtl/sgcf_idle_timer.sv ----
// standstill detection: counts clocks since the last executed step
// assumes step_evt is a one-cycle pulse on clk
`timescale 1ns/10ps
`include "sgcf_cfg.svh"
module sgcf_idle_timer import sgcf_pkg::*; #(
	parameter logic [20:0] SHORT_CLK = `SGCF_IDLE_SHORT_CLK,
	parameter logic [20:0] LONG_CLK = `SGCF_IDLE_LONG_CLK
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic step_evt,
	input wire logic quick,
	output logic standstill
);
	sgcf_idle_type st_ff;
	sgcf_idle_type nxt_st;
	logic [20:0] limit;

	// ------------------------------------------------------------------------
	// counter
	// ------------------------------------------------------------------------
	always_comb begin
		limit = quick ? SHORT_CLK : LONG_CLK; // [R02]
		nxt_st = st_ff;
		if (step_evt) begin
			nxt_st.cnt = 21'h000000;
			nxt_st.still = 1'b0;
		end else if (st_ff.cnt >= limit - 21'h000001) begin
			nxt_st.still = 1'b1; // [R02]
		end else begin
			nxt_st.cnt = st_ff.cnt + 21'h000001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign standstill = st_ff.still;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	a_idle_cleared: assert property (@(posedge clk) disable iff (sys_rst) // [R02]
		step_evt |=> !standstill) else $error("standstill after step");
	a_idle_limit: assert property (@(posedge clk) disable iff (sys_rst) // [R02]
		$rose(standstill) |-> $past(st_ff.cnt) >= limit - 21'h000001)
		else $error("standstill too early");
	c_idle_reached: cover property (@(posedge clk) disable iff (sys_rst) $rose(standstill));
endmodule

// ---- shared/sgcf_cfg.svh ----
// offsets, field positions, reset values and timing counts
// assumes the serial register interface hands over one decoded access per cycle
`ifndef SGCF_CFG_SVH
`define SGCF_CFG_SVH

// ----------------------------------------------------------------------------
// register addressing
// ----------------------------------------------------------------------------
`define SGCF_ADDR_GLOBAL_CONFIG 8'h00
`define SGCF_WRITE_FLAG 8'h80
`define SGCF_CFG_W 18
`define SGCF_CFG_RESET 18'h00008

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SGCF_B_RECALIBRATE 0
`define SGCF_B_QUICK_IDLE 1
`define SGCF_B_VOLTAGE_PWM 2
`define SGCF_B_STEP_FILTER 3
`define SGCF_B_INVERT_DIR 4
`define SGCF_B_FIRST_FAULT 5
`define SGCF_B_FIRST_PREWARN 6
`define SGCF_B_FIRST_STALL 7
`define SGCF_B_SECOND_STALL 8
`define SGCF_B_SECOND_INDEX 9
`define SGCF_B_SECOND_CHOP_ON 10
`define SGCF_B_SECOND_SKIP 11

// ----------------------------------------------------------------------------
// timing, in device clocks
// ----------------------------------------------------------------------------
`define SGCF_IDLE_SHORT_CLK 21'h040000
`define SGCF_IDLE_LONG_CLK 21'h100000
`define SGCF_SEL_SAMPLE 2'h2

`endif

// ---- shared/sgcf_pkg.sv ----
// types shared by the global configuration block and its idle timer
// assumes sgcf_cfg.svh is on the include path
package sgcf_pkg;
	`include "sgcf_cfg.svh"

	typedef struct packed {
		logic over_temp;
		logic short_gnd;
		logic pump_undervoltage;
		logic prewarning;
		logic stall;
		logic chopper_on;
		logic skipped_inc;
		logic interrupt_req;
		logic position_compare;
	} sgcf_event_type;

	typedef struct packed {
		logic [`SGCF_CFG_W-1:0] cfg;
		logic [1:0] init_cnt;
		logic sel;
		logic [1:0] en_s;
		logic [1:0] step_s;
		logic [1:0] dir_s;
		logic [1:0] sel_s;
		logic step_q;
		logic step_q2;
		logic step_tgl;
		logic skip_tgl;
		logic motor_dir;
		logic recal;
		logic act0;
		logic act1;
		logic [31:0] rdata;
		logic rvalid;
	} sgcf_state_type;

	typedef struct packed {
		logic [20:0] cnt;
		logic still;
	} sgcf_idle_type;
endpackage

// ---- test/sgcf_host.sv ----
// host model on the serial register interface: one access per request pulse
// assumes requests are taken at a rising clk edge and reads answer a cycle later
`timescale 1ns/10ps
module sgcf_host (
	input wire logic clk,
	output logic reg_req,
	output logic [7:0] reg_addr,
	output logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_req = 1'h0;
		reg_addr = 8'h7f;
		reg_wdata = 32'h0;
	end

	// ------------------------------------------------------------------------
	// accesses
	// ------------------------------------------------------------------------
	task automatic access(input logic [7:0] addr, input logic [31:0] data);
		@(posedge clk);
		reg_req <= 1'h1;
		reg_addr <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_req <= 1'h0;
		reg_addr <= ~addr;
		reg_wdata <= ~data;
	endtask

	// write uses the address plus the write flag
	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		access(addr | 8'h80, data);
	endtask

	// read uses the plain address
	task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic ok);
		int k;
		ok = 1'h0;
		data = 32'h0;
		access(addr, 32'h0);
		for (k = 0; k < 3; k++) begin
			@(posedge clk);
			if (reg_rvalid === 1'h1 && !ok) begin
				data = reg_rdata;
				ok = 1'h1;
			end
		end
	endtask
endmodule

// ---- test/tb_stepper_global_config_flags.sv ----
// testbench for the global configuration word and diagnostic routing
// assumes sgcf_host drives the register port; idle limits shortened to 16/64
`timescale 1ns/10ps
module tb_stepper_global_config_flags import sgcf_pkg::*;;
	typedef struct packed {
		logic m;
		logic [17:0] cfg;
		logic [8:0] ev;
		logic ix;
		logic f;
		logic s;
	} sgcf_row_type;
	logic clk, sys_rst, reg_req, reg_rvalid, driver_enable_n, step_pin, dir_pin, ext_sel;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [3:0] chopper_off_time;
	logic [9:0] mslut_position;
	sgcf_event_type event_in;
	logic step_executed, motor_direction, standstill, recal, vpwm, sfilt, first_n, second_n;
	logic ok, f0, mode;
	int miscompares, n_checks, steps, s0, i, q, lim;
	sgcf_row_type rows [15] = '{
		'{1'h0, 18'h00008, 9'h002, 1'h0, 1'h0, 1'h1},
		'{1'h0, 18'h00028, 9'h100, 1'h0, 1'h1, 1'h1},
		'{1'h0, 18'h00008, 9'h001, 1'h0, 1'h1, 1'h0},
		'{1'h1, 18'h00020, 9'h100, 1'h0, 1'h0, 1'h1},
		'{1'h1, 18'h00020, 9'h080, 1'h0, 1'h0, 1'h1},
		'{1'h1, 18'h00020, 9'h040, 1'h0, 1'h0, 1'h1},
		'{1'h1, 18'h00020, 9'h020, 1'h0, 1'h1, 1'h1},
		'{1'h1, 18'h00040, 9'h020, 1'h0, 1'h0, 1'h1},
		'{1'h1, 18'h00080, 9'h010, 1'h0, 1'h0, 1'h1},
		'{1'h1, 18'h00080, 9'h002, 1'h0, 1'h1, 1'h1},
		'{1'h1, 18'h00100, 9'h010, 1'h0, 1'h1, 1'h0},
		'{1'h1, 18'h00200, 9'h000, 1'h1, 1'h1, 1'h0},
		'{1'h1, 18'h00200, 9'h000, 1'h0, 1'h1, 1'h1},
		'{1'h1, 18'h00400, 9'h008, 1'h0, 1'h1, 1'h0},
		'{1'h1, 18'h00000, 9'h1fb, 1'h1, 1'h1, 1'h1}
	};

	sgcf_host host (.clk(clk), .reg_req(reg_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	sgcf_global_config #(.IDLE_SHORT_CLK(21'h000010), .IDLE_LONG_CLK(21'h000040)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.driver_enable_n(driver_enable_n), .step_pin(step_pin), .dir_pin(dir_pin),
		.external_step_output_select(ext_sel), .chopper_off_time(chopper_off_time),
		.mslut_position(mslut_position), .event_in(event_in), .step_executed(step_executed),
		.motor_direction(motor_direction), .standstill(standstill), .recalibrate_active(recal),
		.voltage_pwm_enable(vpwm), .step_filter_enable(sfilt),
		.first_diagnostic_output_n(first_n), .second_diagnostic_output_n(second_n));

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) if (step_executed === 1'h1) steps <= steps + 1;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic do_reset(input logic m);
		@(posedge clk);
		ext_sel <= m;
		sys_rst <= 1'h1;
		repeat (16) @(posedge clk);
		chk("first_n in reset", 0, first_n);
		sys_rst <= 1'h0;
		repeat (6) @(posedge clk);
		mode = m;
	endtask

	task automatic do_step();
		int k;
		@(posedge clk);
		step_pin <= 1'h1;
		repeat (2) @(posedge clk);
		step_pin <= 1'h0;
		for (k = 0; k < 10 && step_executed !== 1'h1; k++) @(posedge clk);
		chk("step_executed", 1, step_executed);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		close_out();
	end

	// ------------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------------
	initial begin
		{sys_rst, driver_enable_n, step_pin, dir_pin, ext_sel} = 5'h10;
		chopper_off_time = 4'h3;
		mslut_position = 10'h155;
		event_in = '0;
		do_reset(1'h0);
		host.rd(8'h00, d, ok);
		chk("reset value", 32'h00000008, d);
		chk("step_filter_enable", 1, sfilt);
		for (i = 0; i < 15; i++) begin
			if (rows[i].m !== mode) do_reset(rows[i].m);
			host.wr(8'h00, {14'h0, rows[i].cfg});
			event_in <= rows[i].ev;
			mslut_position <= rows[i].ix ? 10'h000 : 10'h155;
			repeat (3) @(posedge clk);
			chk("first_n", rows[i].f, first_n);
			chk("second_n", rows[i].s, second_n);
		end
		event_in <= '0;
		host.wr(8'h00, 32'h00000800);
		repeat (3) @(posedge clk);
		f0 = second_n;
		for (q = 0; q < 2; q++) begin
			@(posedge clk);
			event_in <= 9'h004;
			@(posedge clk);
			event_in <= '0;
			repeat (3) @(posedge clk);
			chk("second_n skip", q ? f0 : !f0, second_n);
		end
		do_reset(1'h0);
		for (q = 0; q < 2; q++) begin
			lim = q ? 64 : 16;
			host.wr(8'h00, q ? 32'h00000198 : 32'h0000019a);
			repeat (4) @(posedge clk);
			f0 = first_n;
			do_step();
			repeat (lim / 2) @(posedge clk);
			chk("standstill early", 0, standstill);
			repeat (lim / 2 + 4) @(posedge clk);
			chk("standstill", 1, standstill);
			chk("first_n step", !f0, first_n);
			chk("motor_direction", 1, motor_direction);
			chk("second_n dir", 0, second_n);
		end
		for (q = 0; q < 2; q++) begin
			host.wr(8'h00, q ? 32'h00000198 : 32'h00000190);
			s0 = steps;
			@(posedge clk);
			step_pin <= 1'h1;
			@(posedge clk);
			step_pin <= 1'h0;
			repeat (8) @(posedge clk);
			chk("glitch steps", q ? s0 : s0 + 1, steps);
		end
		host.wr(8'h00, 32'h00000004);
		repeat (2) @(posedge clk);
		chk("voltage_pwm_enable", 1, vpwm);
		host.wr(8'h00, 32'h00000001);
		for (q = 0; q < 3; q++) begin
			driver_enable_n <= (q == 1);
			chopper_off_time <= (q == 2) ? 4'h0 : 4'h3;
			repeat (6) @(posedge clk);
			chk("recalibrate_active", q != 0, recal);
		end
		host.rd(8'h01, d, ok);
		chk("unmapped rvalid", 0, ok);
		host.wr(8'h01, 32'h0);
		host.rd(8'h00, d, ok);
		chk("after unmapped write", 32'h00000001, d);
		host.wr(8'h00, 32'hffffffff);
		host.rd(8'h00, d, ok);
		chk("readback", 32'h0003ffff, d);
		close_out();
	end
endmodule
